// ---- rtl/cpw_pwm12.sv ----
/*
 * cascaded 12-bit pwm generator with its AHB-Lite register slave.
 * assumes one AHB-Lite master doing single word transfers, OKAY only.
 */
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cpw_pwm12
    import cpw_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // timer pins
    input  wire logic        timerInputPin,
    output logic             pwmOutputPin,
    // event pulses
    output logic             overflowIrq,
    output logic             frameIrq
);

    // ************************************************************
    // declarations
    // ************************************************************
    cpw_ctrl_t   ctrl_reg;
    cpw_mode_t   mode_reg;
    logic [7:0]  dutyLowStage_reg;
    logic [7:0]  dutyHighRaw_reg;
    logic [11:0] dutyBuf_reg;
    logic [11:0] dutyAct_reg;
    logic [7:0]  count_reg;
    logic [3:0]  period_reg;
    logic        wrPend_reg;
    logic [7:0]  wrAddr_reg;
    logic [31:0] rdData_next;
    logic        busTake;
    logic        wrCtrl;
    logic        wrMode;
    logic        wrLow;
    logic        wrHigh;
    logic        running;
    logic        srcTick;
    logic        ovfEvent;
    logic        frameEvent;
    logic        stretch;
    logic [8:0]  target;
    logic        match;
    logic [11:0] dutyRead;

    // ************************************************************
    // source clock
    // ************************************************************
    cpw_clk_select u_clk_select (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .extSel        (mode_reg.externalClockSelect),
        .srcSel        (mode_reg.sourceClockSelect),
        .timerInputPin (timerInputPin),
        .srcTick       (srcTick)
    );

    // ************************************************************
    // bus slave
    // ************************************************************
    // address phase accepted when selected and not idle
    assign busTake = hsel & htrans[1] & hready;

    // capture write address phase for use in data phase
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else begin
            wrPend_reg <= busTake & hwrite;
            wrAddr_reg <= haddr[7:0];
        end
    end

    // data phase write strobes per register
    assign wrCtrl = wrPend_reg & (wrAddr_reg == CPW_OFS_CTRL);
    assign wrMode = wrPend_reg & (wrAddr_reg == CPW_OFS_MODE);
    assign wrLow  = wrPend_reg & (wrAddr_reg == CPW_OFS_DUTY_LOW);
    assign wrHigh = wrPend_reg & (wrAddr_reg == CPW_OFS_DUTY_HIGH);

    // buffered duty shown when buffering is on
    assign dutyRead = mode_reg.bufferEnable ? dutyBuf_reg : dutyAct_reg; // [RL16]

    // read mux, unmapped addresses read zero
    always_comb begin
        rdData_next = 32'h0000_0000;
        case (haddr[7:0])
            CPW_OFS_CTRL:      rdData_next[2:0] = ctrl_reg;
            CPW_OFS_MODE:      rdData_next[7:0] = mode_reg;
            CPW_OFS_DUTY_LOW:  rdData_next[7:0] = dutyRead[7:0];
            CPW_OFS_DUTY_HIGH: rdData_next[7:0] = {dutyHighRaw_reg[7:4], dutyRead[11:8]};
            CPW_OFS_STATUS:    rdData_next[12:0] = {running, period_reg, count_reg};
            default:           rdData_next = 32'h0000_0000;
        endcase
    end

    // read data registered for the data phase
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
        end else if (busTake & ~hwrite) begin
            hrdata <= rdData_next;
        end
    end

    // zero wait state slave, always OKAY
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // control and mode registers
    // ************************************************************
    // control register: run bits and cascade select
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CPW_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_reg <= hwdata[2:0];
        end
    end

    // mode register locked while the upper timer runs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mode_reg <= CPW_MODE_RST;
        end else if (wrMode & ~ctrl_reg.upperRunBit) begin // [RL23]
            mode_reg <= hwdata[7:0];
        end
    end

    // cascade plus mode ten, upper settings only, lower run ignored
    assign running = ctrl_reg.cascadeSelect & ctrl_reg.upperRunBit
                   & (mode_reg.upperModeSelect == CPW_MODE_PWM12); // [RL22]

    // ************************************************************
    // duty registers
    // ************************************************************
    // low byte is staged until the high byte is written
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dutyLowStage_reg <= CPW_DUTY_RST;
        end else if (wrLow) begin
            dutyLowStage_reg <= hwdata[7:0]; // [RL20]
        end
    end

    // raw high byte, upper nibble reads back as written
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dutyHighRaw_reg <= CPW_DUTY_RST;
        end else if (wrHigh) begin
            dutyHighRaw_reg <= hwdata[7:0];
        end
    end

    // buffer takes every committed value
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dutyBuf_reg <= {CPW_DUTY_RST[3:0], CPW_DUTY_RST};
        end else if (wrHigh) begin
            dutyBuf_reg <= {hwdata[3:0], dutyLowStage_reg}; // [RL20] [RL21]
        end
    end

    // active duty: direct when stopped or unbuffered, else at frame end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dutyAct_reg <= {CPW_DUTY_RST[3:0], CPW_DUTY_RST};
        end else if (wrHigh & ~(running & mode_reg.bufferEnable)) begin
            dutyAct_reg <= {hwdata[3:0], dutyLowStage_reg}; // [RL14] [RL17] [RL18]
        end else if (frameEvent & mode_reg.bufferEnable) begin
            dutyAct_reg <= dutyBuf_reg; // [RL15]
        end
    end

    // ************************************************************
    // counter and period index
    // ************************************************************
    // overflow when the count passes 255 on a source tick
    assign ovfEvent   = running & srcTick & (count_reg == CPW_CNT_MAX); // [RL8]
    assign frameEvent = ovfEvent & (period_reg == CPW_PERIOD_LAST); // [RL10]

    // up counter, wraps to zero at 256, cleared when stopped
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_reg <= 8'h00;
        end else if (~running) begin
            count_reg <= 8'h00; // [RL11]
        end else if (srcTick) begin
            count_reg <= count_reg + 1'b1; // [RL4] [RL8]
        end
    end

    // period index within the sixteen-period frame
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            period_reg <= 4'h0;
        end else if (~running) begin
            period_reg <= 4'h0; // [RL24]
        end else if (ovfEvent) begin
            period_reg <= period_reg + 1'b1; // [RL24]
        end
    end

    // ************************************************************
    // extra pulse selection and match
    // ************************************************************
    // union of periods picked by each extra-pulse bit, index is period minus one
    assign stretch = (dutyAct_reg[0] & (period_reg == CPW_IDX_AD0))
                   | (dutyAct_reg[1] & (period_reg[2:0] == CPW_IDX_AD1))
                   | (dutyAct_reg[2] & (period_reg[1:0] == CPW_IDX_AD2))
                   | (dutyAct_reg[3] & (period_reg[0] == CPW_IDX_AD3)); // [RL1] [RL7] [RL25]

    // compare point, one count later in stretched periods
    assign target = {1'b0, dutyAct_reg[11:4]} + {8'h00, stretch}; // [RL6]

    // level compare so a fresh equal duty matches right after the write
    assign match = running & ({1'b0, count_reg} == target); // [RL5] [RL19]

    // ************************************************************
    // output pin
    // ************************************************************
    // idle level when stopped, restored at overflow, inverted at match
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pwmOutputPin <= CPW_MODE_RST.outputInitialLevel;
        end else if (~running) begin
            pwmOutputPin <= mode_reg.outputInitialLevel; // [RL2] [RL3] [RL11]
        end else if (ovfEvent) begin
            pwmOutputPin <= mode_reg.outputInitialLevel; // [RL8]
        end else if (match) begin
            pwmOutputPin <= ~mode_reg.outputInitialLevel; // [RL5]
        end
    end

    // ************************************************************
    // event pulses
    // ************************************************************
    // one-cycle requests on overflow and frame end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            overflowIrq <= 1'b0;
            frameIrq    <= 1'b0;
        end else begin
            overflowIrq <= ovfEvent; // [RL9]
            frameIrq    <= frameEvent; // [RL10]
        end
    end

endmodule : cpw_pwm12

// ---- pkg/cpw_pkg.sv ----
/*
 * constants, register map and field layouts of the cascaded 12-bit pwm block.
 * assumes one 100 MHz clock and a single AHB-Lite master with word accesses.
 */
// Contract
// (RL1) bit0 p9, bit1 p5/13, bit2 p3/7/11/15, bit3 even
// (RL2) initial-level bit picks output idle level
// (RL3) stopped timer drives output with initial level
// (RL4) run bit set: count once per source clock
// (RL5) low count equals duty: invert output
// (RL6) selected periods invert at duty plus one
// (RL7) all extra bits zero: no stretched period
// (RL8) count 256 overflows, clears, restores initial level
// (RL9) overflow request on every overflow
// (RL10) frame request on every sixteenth overflow
// (RL11) run bit cleared: stop, clear, restore level
// (RL12) external clock at most half system clock
// (RL13) external clock holds each level two cycles
// (RL14) buffer-enable bit turns duty double buffer on
// (RL15) running buffered writes land at frame end
// (RL16) buffered duty reads return buffer contents
// (RL17) stopped writes update active duty at once
// (RL18) unbuffered write acts now, low value waits
// (RL19) unbuffered write equal count inverts at once
// (RL20) write low then high; high commits both
// (RL21) duty split: high nibble, duty low, extras
// (RL22) cascade with mode ten enables this mode
// (RL23) mode register writes ignored once started
// (RL24) period index advances per overflow, clears stopped
// (RL25) extra-pulse bits combine as union of periods
package cpw_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] CPW_OFS_CTRL      = 8'h00;
    localparam logic [7:0] CPW_OFS_MODE      = 8'h04;
    localparam logic [7:0] CPW_OFS_DUTY_LOW  = 8'h08;
    localparam logic [7:0] CPW_OFS_DUTY_HIGH = 8'h0C;
    localparam logic [7:0] CPW_OFS_STATUS    = 8'h10;

    // ************************************************************
    // field layouts and reset values
    // ************************************************************
    typedef struct packed {
        logic cascadeSelect;
        logic upperRunBit;
        logic lowerRunBit;
    } cpw_ctrl_t;

    typedef struct packed {
        logic       outputInitialLevel;
        logic       bufferEnable;
        logic [2:0] sourceClockSelect;
        logic       externalClockSelect;
        logic [1:0] upperModeSelect;
    } cpw_mode_t;

    localparam cpw_ctrl_t  CPW_CTRL_RST  = 3'h0;
    localparam cpw_mode_t  CPW_MODE_RST  = 8'h00;
    localparam logic [7:0] CPW_DUTY_RST  = 8'hFF;
    localparam logic [1:0] CPW_MODE_PWM12 = 2'h2;

    // ************************************************************
    // counter and frame constants
    // ************************************************************
    localparam logic [7:0] CPW_CNT_MAX     = 8'hFF;
    localparam logic [3:0] CPW_PERIOD_LAST = 4'hF;
    localparam logic [3:0] CPW_IDX_AD0     = 4'h8;
    localparam logic [2:0] CPW_IDX_AD1     = 3'h4;
    localparam logic [1:0] CPW_IDX_AD2     = 2'h2;
    localparam logic       CPW_IDX_AD3     = 1'h1;

    // ************************************************************
    // prescaler masks (divide by mask + 1) per source clock code
    // ************************************************************
    localparam int         CPW_DIV_W   = 11;
    localparam logic [10:0] CPW_MASK_0 = 11'h7FF;
    localparam logic [10:0] CPW_MASK_1 = 11'h3FF;
    localparam logic [10:0] CPW_MASK_2 = 11'h0FF;
    localparam logic [10:0] CPW_MASK_3 = 11'h03F;
    localparam logic [10:0] CPW_MASK_4 = 11'h00F;
    localparam logic [10:0] CPW_MASK_5 = 11'h003;
    localparam logic [10:0] CPW_MASK_6 = 11'h001;
    localparam logic [10:0] CPW_MASK_7 = 11'h000;

endpackage : cpw_pkg

// ---- rtl/cpw_clk_select.sv ----
/*
 * source clock tick generator: internal prescaler or external pin edge.
 * assumes the timer input pin is synchronous to ref_clk.
 */
`timescale 1ns/1ps
module cpw_clk_select
    import cpw_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // selection
    input  wire logic       extSel,
    input  wire logic [2:0] srcSel,
    // external clock pin
    input  wire logic       timerInputPin,
    // one-cycle source clock tick
    output logic            srcTick
);

    logic [CPW_DIV_W-1:0] div_reg;
    logic [CPW_DIV_W-1:0] mask;
    logic                 pinPrev_reg;

    // mask of prescaler bits for the chosen divide ratio
    always_comb begin
        case (srcSel)
            3'h0:    mask = CPW_MASK_0;
            3'h1:    mask = CPW_MASK_1;
            3'h2:    mask = CPW_MASK_2;
            3'h3:    mask = CPW_MASK_3;
            3'h4:    mask = CPW_MASK_4;
            3'h5:    mask = CPW_MASK_5;
            3'h6:    mask = CPW_MASK_6;
            default: mask = CPW_MASK_7;
        endcase
    end

    // free-running prescaler
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // previous pin level for falling edge detection
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinPrev_reg <= 1'b0;
        end else begin
            pinPrev_reg <= timerInputPin;
        end
    end

    // tick on external falling edge, relies on slow enough pin [RL12] [RL13]
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            srcTick <= 1'b0;
        end else if (extSel) begin
            srcTick <= pinPrev_reg & ~timerInputPin;
        end else begin
            srcTick <= ((div_reg & mask) == mask);
        end
    end

endmodule : cpw_clk_select

// ---- dv/cpw_pwm12_properties.sv ----
/*
 * port checker of cpw_pwm12, bound into the design.
 * assumes word writes, a one-cycle data phase and the cpw_pkg map.
 */
`timescale 1ns/1ps
module cpw_pwm12_properties
    import cpw_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    // timer outputs
    input wire logic        pwmOutputPin,
    input wire logic        overflowIrq,
    input wire logic        frameIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ************************************************************
    // shadow of control and mode, overflow bookkeeping
    // ************************************************************
    logic       wrPend;
    logic [7:0] wrAddr;
    cpw_ctrl_t  ctrlReg;
    cpw_mode_t  modeReg;
    logic       running;
    logic       ovfSeen;
    logic [9:0] gap;
    logic [3:0] ovfCnt;
    logic       initLvl;

    assign running = ctrlReg.cascadeSelect & ctrlReg.upperRunBit
        & (modeReg.upperModeSelect == CPW_MODE_PWM12);
    assign initLvl = modeReg.outputInitialLevel;

    // write address phase capture
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= hsel & htrans[1] & hwrite;
            wrAddr <= haddr[7:0];
        end
    end

    // register shadow, mode locked while the upper run bit is set
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrlReg <= CPW_CTRL_RST;
            modeReg <= CPW_MODE_RST;
        end else if (wrPend && wrAddr == CPW_OFS_CTRL) begin
            ctrlReg <= hwdata[2:0];
        end else if (wrPend && wrAddr == CPW_OFS_MODE && !ctrlReg.upperRunBit) begin
            modeReg <= hwdata[7:0];
        end
    end

    // cycles since last overflow and overflows since start
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset || !running) begin
            ovfSeen <= 1'b0;
            gap     <= 10'h000;
            ovfCnt  <= 4'h0;
        end else if (overflowIrq) begin
            ovfSeen <= 1'b1;
            gap     <= 10'h000;
            ovfCnt  <= ovfCnt + 4'h1;
        end else if (gap != 10'h3FF) begin
            gap <= gap + 10'h001;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    AST_OVF_PULSE: assert property (overflowIrq |=> !overflowIrq)
        else $error("overflow pulse longer than one cycle");
    AST_OVF_GAP: assert property (overflowIrq && ovfSeen |-> gap >= 10'h0FF)
        else $error("overflows closer than 256 source clocks");
    AST_FRAME_COUNT: assert property (overflowIrq |-> frameIrq == (ovfCnt == 4'hF))
        else $error("frame pulse not on the sixteenth overflow");
    AST_FRAME_WITH_OVF: assert property (frameIrq |-> overflowIrq)
        else $error("frame pulse without overflow");
    AST_OVF_LEVEL: assert property (overflowIrq |-> pwmOutputPin == initLvl)
        else $error("output not at initial level at overflow");
    AST_STOP_LEVEL: assert property (!running && !$past(running) && !$past(running, 2)
        && modeReg == $past(modeReg) |-> pwmOutputPin == initLvl)
        else $error("stopped output differs from initial level");
    AST_STOP_RETURN: assert property ($fell(running) |-> ##[1:3] pwmOutputPin == initLvl)
        else $error("output did not return after stop");
    AST_IDLE_QUIET: assert property (!running && !$past(running) |-> !overflowIrq throughout ##1 !frameIrq)
        else $error("overflow while stopped");

    cover property (frameIrq);
    cover property ($fell(running));
    cover property (overflowIrq && modeReg.bufferEnable);
endmodule : cpw_pwm12_properties

bind cpw_pwm12 cpw_pwm12_properties chk_u (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .pwmOutputPin(pwmOutputPin),
    .overflowIrq(overflowIrq), .frameIrq(frameIrq)
);

// ---- dv/cpw_ext_clk_source.sv ----
/*
 * external clock source on the timer input pin.
 * assumes the bench enables it only while external clocking is tested.
 */
`timescale 1ns/1ps
module cpw_ext_clk_source (
    // clock
    input  wire logic       ref_clk,
    // bench control
    input  wire logic       clkEnable,
    input  wire logic [3:0] halfPeriod,
    // pin to the timer
    output logic            timerInputPin
);
    logic [3:0] phaseCnt;

    // toggles every halfPeriod cycles, stands high when disabled
    always @(posedge ref_clk) begin
        if (!clkEnable) begin
            timerInputPin <= 1'b1;
            phaseCnt      <= 4'h0;
        end else if (phaseCnt + 4'h1 >= halfPeriod) begin
            timerInputPin <= ~timerInputPin;
            phaseCnt      <= 4'h0;
        end else begin
            phaseCnt <= phaseCnt + 4'h1;
        end
    end
endmodule : cpw_ext_clk_source

// ---- dv/test_cpw_pwm12.sv ----
/*
 * self-checking bench of cpw_pwm12: bus tasks and period measurement.
 * assumes the checker is bound and the external clock model is present.
 */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module test_cpw_pwm12
    import cpw_pkg::*;
();
    logic        ref_clk, reset, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        timerInputPin, pwmOutputPin, overflowIrq, frameIrq, extEn;
    logic [3:0]  extHalf;
    int          nErrors, cmpCount;

    cpw_pwm12 dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timerInputPin(timerInputPin),
        .pwmOutputPin(pwmOutputPin), .overflowIrq(overflowIrq), .frameIrq(frameIrq));
    cpw_ext_clk_source ext_u (.ref_clk(ref_clk), .clkEnable(extEn), .halfPeriod(extHalf),
        .timerInputPin(timerInputPin));

    // ************************************************************
    // bus and measurement tasks
    // ************************************************************
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        `CHK("okay", 1'b0, hresp)
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        ahb(a, 1'b1, {24'h000000, d}, r);
    endtask : wr
    task automatic set_duty(input logic [7:0] duty, input logic [3:0] e);
        wr(CPW_OFS_DUTY_LOW, {duty[3:0], e});
        wr(CPW_OFS_DUTY_HIGH, {4'h0, duty[7:4]});
    endtask : set_duty
    task automatic start(input logic [7:0] mode, input logic [7:0] duty, input logic [3:0] e);
        wr(CPW_OFS_CTRL, 8'h00);
        wr(CPW_OFS_MODE, mode);
        set_duty(duty, e);
        wr(CPW_OFS_CTRL, 8'h06);
    endtask : start
    // counts off-initial cycles up to and including the next overflow pulse
    task automatic win(input logic init, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            if (pwmOutputPin !== init) n++;
        end while (overflowIrq !== 1'b1);
    endtask : win
    function automatic int stretch(input int p, input logic [3:0] e);
        return (e[0] && p == 9) || (e[1] && (p == 5 || p == 13))
            || (e[2] && p % 4 == 3) || (e[3] && p % 2 == 0);
    endfunction : stretch
    task automatic check_frame(input logic [7:0] duty, input logic [3:0] e, input logic init);
        int n;
        do @(posedge ref_clk); while (frameIrq !== 1'b1);
        for (int p = 1; p <= 16; p++) begin
            win(init, n);
            `CHK("active time", 255 - duty - stretch(p, e), n)
            `CHK("frame pulse", p == 16, frameIrq)
        end
    endtask : check_frame

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        logic [7:0]  a [5] = '{CPW_OFS_CTRL, CPW_OFS_MODE, CPW_OFS_DUTY_LOW,
                               CPW_OFS_DUTY_HIGH, 8'h14};
        logic [31:0] e [5] = '{32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0};
        logic [31:0] r, r2;
        `CHK("reset pin", 1'b0, pwmOutputPin)
        wr(8'h14, 8'h5A);
        for (int i = 0; i < 5; i++) begin
            ahb(a[i], 1'b0, 32'h0, r);
            `CHK("reset value", e[i], r)
        end
        for (int i = 1; i >= 0; i--) begin
            wr(CPW_OFS_MODE, {i[0], 7'h3A});
            repeat (3) @(posedge ref_clk);
            `CHK("idle level", i[0], pwmOutputPin)
        end
        wr(CPW_OFS_CTRL, 8'h02);
        ahb(CPW_OFS_STATUS, 1'b0, 32'h0, r);
        `CHK("no cascade", 1'b0, r[12])
        wr(CPW_OFS_CTRL, 8'h06);
        wr(CPW_OFS_MODE, 8'hFF);
        ahb(CPW_OFS_MODE, 1'b0, 32'h0, r);
        `CHK("mode lock", 32'h3A, r)
        ahb(CPW_OFS_STATUS, 1'b0, 32'h0, r);
        ahb(CPW_OFS_STATUS, 1'b0, 32'h0, r2);
        `CHK("count step", 8'h03, 8'(r2[7:0] - r[7:0]))
        `CHK("running", 1'b1, r2[12])
    endtask : t_regs
    task automatic t_frames;
        logic [7:0] d [3] = '{8'h40, 8'h80, 8'h30};
        logic [3:0] e [3] = '{4'h5, 4'hA, 4'h0};
        for (int i = 0; i < 3; i++) begin
            start({i[0], 7'h3A}, d[i], e[i]);
            check_frame(d[i], e[i], i[0]);
        end
    endtask : t_frames
    task automatic t_buffer;
        logic [31:0] r;
        int n;
        start(8'h7A, 8'h40, 4'h0);
        do @(posedge ref_clk); while (frameIrq !== 1'b1);
        set_duty(8'hA8, 4'h0);
        ahb(CPW_OFS_DUTY_LOW, 1'b0, 32'h0, r);
        `CHK("buffer read", 32'h80, r)
        win(1'b0, n);
        `CHK("old duty kept", 255 - 8'h40, n)
        check_frame(8'hA8, 4'h0, 1'b0);
    endtask : t_buffer
    task automatic t_direct;
        logic [31:0] r;
        int n;
        start(8'h3A, 8'h40, 4'h0);
        do @(posedge ref_clk); while (overflowIrq !== 1'b1);
        set_duty(8'hC0, 4'h0);
        win(1'b0, n);
        `CHK("new duty now", 255 - 8'hC0, n)
        repeat (128) @(posedge ref_clk);
        set_duty(8'h10, 4'h0);
        win(1'b0, n);
        `CHK("below count", 0, n)
        repeat (64) @(posedge ref_clk);
        `CHK("active", 1'b1, pwmOutputPin)
        wr(CPW_OFS_CTRL, 8'h00);
        repeat (2) @(posedge ref_clk);
        `CHK("stop level", 1'b0, pwmOutputPin)
        ahb(CPW_OFS_STATUS, 1'b0, 32'h0, r);
        `CHK("stop status", 32'h0, r)
    endtask : t_direct
    task automatic t_ext;
        int n;
        for (int h = 2; h <= 3; h++) begin
            extHalf <= 4'(h);
            start(8'h3E, 8'h40, 4'h0);
            extEn <= 1'b1;
            do @(posedge ref_clk); while (overflowIrq !== 1'b1);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (overflowIrq !== 1'b1);
            `CHK("ext period", 512 * h, n)
            extEn <= 1'b0;
        end
        wr(CPW_OFS_CTRL, 8'h00);
    endtask : t_ext

    task automatic finishTest;
        if (nErrors == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finishTest

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // main sequence
    initial begin
        {reset, hsize} = 4'b1010;
        {hsel, hwrite, htrans, haddr, hwdata, extEn, extHalf} = '0;
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        t_regs;
        t_frames;
        t_buffer;
        t_direct;
        t_ext;
        finishTest;
    end
    // watchdog
    initial begin
        #700000;
        nErrors++;
        finishTest;
    end
endmodule : test_cpw_pwm12
